// >>> design/cawd_watchdog.sv
`timescale 1ns/1ps
`include "cawd_regs.svh"

module cawd_watchdog (
    // Clock and reset.
    input  wire logic                    clock,
    input  wire logic                    reset_n,
    // Special function register port.
    input  wire logic                    sfr_wr,
    input  wire logic                    sfr_rd,
    input  wire logic [7:0]              sfr_addr,
    input  wire cawd_pkg::cawd_byte_t    sfr_wdata,
    output cawd_pkg::cawd_byte_t         sfr_rdata,
    // System status and timebase sources.
    input  wire logic                    cpu_idle,
    input  wire logic                    timer0_ovf,
    input  wire logic                    ext_count_pin,
    input  wire logic                    ext_osc_pin,
    // Outputs.
    output logic                         pwm_out,
    output logic                         irq,
    output logic                         wdt_reset_req
);
    import cawd_pkg::*;

    logic [7:0]  control_r;
    logic [7:0]  mode_r;
    logic [7:0]  ch4_mode_r;
    logic [7:0]  pwm_mode_r;
    logic [15:0] count_r;
    logic [7:0]  wdt_offset_low_r;
    logic [7:0]  wdt_update_high_r;
    logic [15:0] pwm_cmp_r;
    logic        wdt_on;
    logic        tick;
    logic        step;
    logic        low_ovf;
    logic        full_ovf;
    logic        pwm_match;
    logic        ch4_match;
    logic        wdt_fire;
    logic        pwm_en;

    function automatic logic wr_at(input logic [7:0] a);
        return sfr_wr && sfr_addr == a;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Counter clock enable.
    cawd_tick_gen u_tick (
        .clock         (clock),
        .reset_n       (reset_n),
        .sel           (mode_r[`CAWD_MODE_SEL_LSB +: 3]),
        .timer0_ovf    (timer0_ov_sync()),
        .ext_count_pin (ext_count_pin),
        .ext_osc_pin   (ext_osc_pin),
        .tick          (tick)
    );

    function automatic logic timer0_ov_sync();
        return timer0_ovf;
    endfunction

    assign wdt_on   = mode_r[`CAWD_MODE_EN_BIT] || mode_r[`CAWD_MODE_LOCK_BIT];
    assign step     = tick && (control_r[`CAWD_CTL_RUN_BIT] || wdt_on)
                      && !(cpu_idle && mode_r[`CAWD_MODE_IDLE_BIT]);
    assign low_ovf  = step && count_r[7:0] == 8'hff;
    assign full_ovf = step && count_r == 16'hffff;
    assign pwm_en   = pwm_mode_r[`CAWD_CHM_COMP_BIT];
    assign pwm_match = step && (count_r + 16'h0001) == pwm_cmp_r;
    assign ch4_match = !wdt_on && ch4_mode_r[`CAWD_CHM_COMP_BIT] && ch4_mode_r[`CAWD_CHM_MAT_BIT]
                       && step && (count_r + 16'h0001) == {wdt_update_high_r, wdt_offset_low_r};
    assign wdt_fire = wdt_on && ((low_ovf && wdt_update_high_r == count_r[15:8])
                      || (wr_at(`CAWD_ADDR_CONTROL) && sfr_wdata[`CAWD_CTL_CH4_BIT]));

    ////////////////////////////////////////////////////////////////////////
    // Mode register: enable set on reset, lock sticks until reset.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mode_r <= `CAWD_MODE_RESET;
        end else if (wr_at(`CAWD_ADDR_MODE)) begin
            mode_r[`CAWD_MODE_OVIE_BIT] <= sfr_wdata[`CAWD_MODE_OVIE_BIT];
            if (!wdt_on) begin
                mode_r[`CAWD_MODE_IDLE_BIT] <= sfr_wdata[`CAWD_MODE_IDLE_BIT];
                mode_r[`CAWD_MODE_SEL_LSB +: 3] <= sfr_wdata[`CAWD_MODE_SEL_LSB +: 3];
            end
            if (!mode_r[`CAWD_MODE_LOCK_BIT]) begin
                mode_r[`CAWD_MODE_EN_BIT] <= sfr_wdata[`CAWD_MODE_EN_BIT];
            end
            mode_r[`CAWD_MODE_LOCK_BIT] <= mode_r[`CAWD_MODE_LOCK_BIT]
                                           | sfr_wdata[`CAWD_MODE_LOCK_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register: hardware sets win over software clears.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            control_r <= `CAWD_CONTROL_RESET;
        end else begin
            if (wr_at(`CAWD_ADDR_CONTROL)) begin
                control_r[`CAWD_CTL_RUN_BIT] <= sfr_wdata[`CAWD_CTL_RUN_BIT];
                control_r[`CAWD_CTL_OVF_BIT] <= sfr_wdata[`CAWD_CTL_OVF_BIT];
                control_r[4:0] <= sfr_wdata[4:0];
            end
            if (full_ovf) begin
                control_r[`CAWD_CTL_OVF_BIT] <= 1'b1;
            end
            if (pwm_match && pwm_mode_r[`CAWD_CHM_MAT_BIT]) begin
                control_r[0] <= 1'b1;
            end
            if (ch4_match) begin
                control_r[`CAWD_CTL_CH4_BIT] <= 1'b1;
            end
            control_r[5] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter: writes blocked while the watchdog runs.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= {`CAWD_BYTE_RESET, `CAWD_BYTE_RESET};
        end else if (wr_at(`CAWD_ADDR_CNT_LOW) && !wdt_on) begin
            count_r[7:0] <= sfr_wdata;
        end else if (wr_at(`CAWD_ADDR_CNT_HIGH) && !wdt_on) begin
            count_r[15:8] <= sfr_wdata;
        end else if (step) begin
            count_r <= count_r + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel 4: offset low byte, update high byte.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wdt_offset_low_r  <= `CAWD_BYTE_RESET;
            wdt_update_high_r <= `CAWD_BYTE_RESET;
            ch4_mode_r        <= `CAWD_BYTE_RESET;
        end else begin
            if (wr_at(`CAWD_ADDR_CH4_LOW)) begin
                wdt_offset_low_r <= sfr_wdata;
            end
            if (wr_at(`CAWD_ADDR_CH4_HIGH)) begin
                if (wdt_on) begin
                    wdt_update_high_r <= count_r[15:8] + wdt_offset_low_r;
                end else begin
                    wdt_update_high_r <= sfr_wdata;
                end
            end
            if (wr_at(`CAWD_ADDR_CH4_MODE) && !wdt_on) begin
                ch4_mode_r <= sfr_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel 0 compare value and 16-bit PWM.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pwm_cmp_r  <= 16'h0000;
            pwm_mode_r <= `CAWD_BYTE_RESET;
        end else begin
            if (wr_at(`CAWD_ADDR_PWM_LOW)) begin
                pwm_cmp_r[7:0] <= sfr_wdata;
                pwm_mode_r[`CAWD_CHM_COMP_BIT] <= 1'b0;
            end else if (wr_at(`CAWD_ADDR_PWM_HIGH)) begin
                pwm_cmp_r[15:8] <= sfr_wdata;
                pwm_mode_r[`CAWD_CHM_COMP_BIT] <= 1'b1;
            end else if (wr_at(`CAWD_ADDR_PWM_MODE)) begin
                pwm_mode_r <= sfr_wdata;
            end
        end
    end

    // Output rises at the compare match and falls at the 16-bit overflow, except with a zero compare value.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pwm_out <= 1'b0;
        end else if (!pwm_en || !pwm_mode_r[`CAWD_CHM_PWM_BIT]) begin
            pwm_out <= 1'b0;
        end else if (pwm_mode_r[`CAWD_CHM_PWM16_BIT] && step) begin
            if (full_ovf) begin
                pwm_out <= (pwm_cmp_r == 16'h0000);
            end else if (pwm_match) begin
                pwm_out <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset pulse and interrupt.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wdt_reset_req <= 1'b0;
        end else begin
            wdt_reset_req <= wdt_fire;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= (control_r[`CAWD_CTL_OVF_BIT] && mode_r[`CAWD_MODE_OVIE_BIT])
                   || (control_r[0] && pwm_mode_r[`CAWD_CHM_IE_BIT])
                   || (control_r[`CAWD_CTL_CH4_BIT] && ch4_mode_r[`CAWD_CHM_IE_BIT]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered read data, valid the cycle after sfr_rd.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            unique case (sfr_addr)
                `CAWD_ADDR_CONTROL:  sfr_rdata <= control_r;
                `CAWD_ADDR_MODE:     sfr_rdata <= {mode_r[7:5], 1'b0, mode_r[3:0]};
                `CAWD_ADDR_CH4_MODE: sfr_rdata <= ch4_mode_r;
                `CAWD_ADDR_CNT_LOW:  sfr_rdata <= count_r[7:0];
                `CAWD_ADDR_CNT_HIGH: sfr_rdata <= count_r[15:8];
                `CAWD_ADDR_CH4_LOW:  sfr_rdata <= wdt_offset_low_r;
                `CAWD_ADDR_CH4_HIGH: sfr_rdata <= wdt_update_high_r;
                `CAWD_ADDR_PWM_LOW:  sfr_rdata <= pwm_cmp_r[7:0];
                `CAWD_ADDR_PWM_HIGH: sfr_rdata <= pwm_cmp_r[15:8];
                `CAWD_ADDR_PWM_MODE: sfr_rdata <= pwm_mode_r;
                default:             sfr_rdata <= 8'h00;
            endcase
        end
    end
endmodule // cawd_watchdog

// >>> design/cawd_regs.svh
`ifndef CAWD_REGS_SVH
`define CAWD_REGS_SVH

`define CAWD_ADDR_CONTROL   8'hd8
`define CAWD_ADDR_MODE      8'hd9
`define CAWD_ADDR_CH4_MODE  8'hde
`define CAWD_ADDR_CNT_LOW   8'hf9
`define CAWD_ADDR_CNT_HIGH  8'hfa
`define CAWD_ADDR_CH4_LOW   8'hed
`define CAWD_ADDR_CH4_HIGH  8'hfe
`define CAWD_ADDR_PWM_LOW   8'hfb
`define CAWD_ADDR_PWM_HIGH  8'hfc
`define CAWD_ADDR_PWM_MODE  8'hda

`define CAWD_CTL_OVF_BIT    7
`define CAWD_CTL_RUN_BIT    6
`define CAWD_CTL_CH4_BIT    4
`define CAWD_MODE_IDLE_BIT  7
`define CAWD_MODE_EN_BIT    6
`define CAWD_MODE_LOCK_BIT  5
`define CAWD_MODE_SEL_LSB   1
`define CAWD_MODE_OVIE_BIT  0
`define CAWD_CHM_PWM16_BIT  7
`define CAWD_CHM_COMP_BIT   6
`define CAWD_CHM_MAT_BIT    3
`define CAWD_CHM_PWM_BIT    1
`define CAWD_CHM_IE_BIT     0

`define CAWD_CONTROL_RESET  8'h00
`define CAWD_MODE_RESET     8'h40
`define CAWD_BYTE_RESET     8'h00

`define CAWD_DIV12_COUNT    4'd11
`define CAWD_DIV4_COUNT     4'd3
`define CAWD_DIV8_COUNT     4'd7

`endif

// >>> design/cawd_pkg.sv
package cawd_pkg;
    typedef logic [7:0] cawd_byte_t;
    typedef enum logic [2:0] {
        CAWD_TB_DIV12 = 3'b000,
        CAWD_TB_DIV4  = 3'b001,
        CAWD_TB_T0OVF = 3'b010,
        CAWD_TB_EXT   = 3'b011,
        CAWD_TB_SYS   = 3'b100,
        CAWD_TB_OSC8  = 3'b101
    } cawd_timebase_e;
endpackage

// >>> design/cawd_tick_gen.sv
`timescale 1ns/1ps
`include "cawd_regs.svh"

module cawd_tick_gen (
    // Clock and reset.
    input  wire logic                    clock,
    input  wire logic                    reset_n,
    // Selection and sources.
    input  wire logic [2:0]              sel,
    input  wire logic                    timer0_ovf,
    input  wire logic                    ext_count_pin,
    input  wire logic                    ext_osc_pin,
    // Counter clock enable.
    output logic                         tick
);
    import cawd_pkg::*;

    logic [3:0] div_r;
    logic [2:0] ext_sync_r;
    logic [2:0] osc_sync_r;
    logic [2:0] osc_div_r;
    logic       osc_tick;
    logic       ext_fall;

    ////////////////////////////////////////////////////////////////////////
    // Divider restarts at the divide-by-12 count when that rate is selected, otherwise at the divide-by-4 count.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            div_r <= 4'd0;
        end else if ((sel == CAWD_TB_DIV12 && div_r == `CAWD_DIV12_COUNT) ||
                     (sel != CAWD_TB_DIV12 && div_r >= `CAWD_DIV4_COUNT)) begin
            div_r <= 4'd0;
        end else begin
            div_r <= div_r + 4'd1;
        end
    end

    // Pins pass three flops; only the second and later stages are read.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ext_sync_r <= 3'b111;
            osc_sync_r <= 3'b000;
        end else begin
            ext_sync_r <= {ext_sync_r[1:0], ext_count_pin};
            osc_sync_r <= {osc_sync_r[1:0], ext_osc_pin};
        end
    end

    assign ext_fall = ext_sync_r[2] && !ext_sync_r[1];
    assign osc_tick = osc_sync_r[1] && !osc_sync_r[2] && osc_div_r == 3'(`CAWD_DIV8_COUNT);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            osc_div_r <= 3'd0;
        end else if (osc_sync_r[1] && !osc_sync_r[2]) begin
            osc_div_r <= osc_div_r + 3'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        unique case (sel)
            CAWD_TB_DIV12: tick = (div_r == `CAWD_DIV12_COUNT);
            CAWD_TB_DIV4:  tick = (div_r == `CAWD_DIV4_COUNT);
            CAWD_TB_T0OVF: tick = timer0_ovf;
            CAWD_TB_EXT:   tick = ext_fall;
            CAWD_TB_SYS:   tick = 1'b1;
            CAWD_TB_OSC8:  tick = osc_tick;
            default:       tick = 1'b0;
        endcase
    end
endmodule // cawd_tick_gen

// >>> verification/cawd_watchdog_asserts.sv
`timescale 1ns/1ps
`include "cawd_regs.svh"

module cawd_watchdog_asserts (
    // Clock and reset.
    input wire logic                 clock,
    input wire logic                 reset_n,
    // Register port.
    input wire logic                 sfr_wr,
    input wire logic                 sfr_rd,
    input wire logic [7:0]           sfr_addr,
    input wire cawd_pkg::cawd_byte_t sfr_wdata,
    input wire cawd_pkg::cawd_byte_t sfr_rdata,
    // Sources.
    input wire logic                 cpu_idle,
    input wire logic                 timer0_ovf,
    input wire logic                 ext_count_pin,
    input wire logic                 ext_osc_pin,
    // Outputs.
    input wire logic                 pwm_out,
    input wire logic                 irq,
    input wire logic                 wdt_reset_req
);
    import cawd_pkg::*;
    logic [7:0] mode_r;
    logic [7:0] mode_nxt;
    logic       run_r;
    logic       comp_off_r;
    logic       wd_on;
    assign wd_on = mode_r[6] | mode_r[5];
    // Model of the mode register: frozen fields keep their value while on.
    always_comb begin
        mode_nxt    = wd_on ? mode_r : sfr_wdata;
        mode_nxt[6] = sfr_wdata[6] | (mode_r[5] & mode_r[6]);
        mode_nxt[5] = mode_r[5] | sfr_wdata[5];
        mode_nxt[4] = 1'b0;
        mode_nxt[0] = sfr_wdata[0];
    end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) mode_r <= `CAWD_MODE_RESET;
        else if (sfr_wr && sfr_addr == `CAWD_ADDR_MODE) mode_r <= mode_nxt;
    end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) run_r <= 1'b0;
        else if (sfr_wr && sfr_addr == `CAWD_ADDR_CONTROL) run_r <= sfr_wdata[6];
    end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) comp_off_r <= 1'b1;
        else if (sfr_wr && sfr_addr == `CAWD_ADDR_PWM_LOW) comp_off_r <= 1'b1;
        else if (sfr_wr && sfr_addr == `CAWD_ADDR_PWM_HIGH) comp_off_r <= 1'b0;
        else if (sfr_wr && sfr_addr == `CAWD_ADDR_PWM_MODE) comp_off_r <= ~sfr_wdata[6];
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    req_pulse_a: assert property (wdt_reset_req |=> !wdt_reset_req)
        else $error("reset request longer than one cycle");
    force_reset_a: assert property (sfr_wr && sfr_addr == `CAWD_ADDR_CONTROL
        && sfr_wdata[4] && wd_on |=> wdt_reset_req) else $error("forced reset missing");
    off_quiet_a: assert property (!wd_on && !$past(wd_on) |-> !wdt_reset_req)
        else $error("reset request while watchdog off");
    mode_read_a: assert property (sfr_rd && !sfr_wr && sfr_addr == `CAWD_ADDR_MODE
        |=> sfr_rdata == $past(mode_r)) else $error("mode register read wrong");
    run_read_a: assert property (sfr_rd && !sfr_wr && sfr_addr == `CAWD_ADDR_CONTROL
        |=> sfr_rdata[6] == $past(run_r) && !sfr_rdata[5]) else $error("run bit read wrong");
    rdata_hold_a: assert property (!$past(sfr_rd) |-> $stable(sfr_rdata))
        else $error("read data changed without read");
    unmapped_read_a: assert property (sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    pwm_off_a: assert property (comp_off_r && $past(comp_off_r) |-> !pwm_out)
        else $error("pwm high with comparator off");
endmodule // cawd_watchdog_asserts

bind cawd_watchdog cawd_watchdog_asserts chk_u (.clock(clock), .reset_n(reset_n),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .cpu_idle(cpu_idle), .timer0_ovf(timer0_ovf),
    .ext_count_pin(ext_count_pin), .ext_osc_pin(ext_osc_pin), .pwm_out(pwm_out),
    .irq(irq), .wdt_reset_req(wdt_reset_req));

// >>> verification/cawd_watchdog_tb.sv
`timescale 1ns/1ps
`include "cawd_regs.svh"

module cawd_watchdog_tb;
    import cawd_pkg::*;
    logic       clock = 1'b0, reset_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    cawd_byte_t sfr_wdata = 8'h00, sfr_rdata, rv, lo, lo0;
    logic       cpu_idle = 1'b0, timer0_ovf = 1'b0, ext_count_pin = 1'b0;
    logic       ext_osc_pin = 1'b0, pwm_out, irq, wdt_reset_req;
    int         err_total = 0, num_checks = 0, cyc = 0, req_cnt = 0, t0, n_req, w;

    cawd_watchdog dut_u (.clock(clock), .reset_n(reset_n), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .cpu_idle(cpu_idle), .timer0_ovf(timer0_ovf), .ext_count_pin(ext_count_pin),
        .ext_osc_pin(ext_osc_pin), .pwm_out(pwm_out), .irq(irq),
        .wdt_reset_req(wdt_reset_req));

    initial begin
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (wdt_reset_req === 1'b1) req_cnt <= req_cnt + 1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input cawd_byte_t d);
        @(negedge clock);
        sfr_wr = 1'b1;
        sfr_addr = a;
        sfr_wdata = d;
        @(negedge clock);
        sfr_wr = 1'b0;
    endtask
    // The extra cycle lets the registered read data settle.
    task automatic rd(input logic [7:0] a, output cawd_byte_t d);
        @(negedge clock);
        sfr_rd = 1'b1;
        sfr_addr = a;
        @(negedge clock);
        sfr_rd = 1'b0;
        @(negedge clock);
        d = sfr_rdata;
    endtask
    task automatic rdc(input logic [7:0] a, input cawd_byte_t exp);
        cawd_byte_t d;
        rd(a, d);
        chk(16'(d), 16'(exp));
    endtask
    task automatic do_reset();
        @(negedge clock);
        reset_n = 1'b0;
        repeat (12) @(negedge clock);
        reset_n = 1'b1;
        t0 = cyc;
    endtask
    // Waits for the reset request and checks its distance from t0.
    task automatic wait_req(input int lo_c, input int hi_c);
        int n;
        n = 0;
        while (wdt_reset_req !== 1'b1 && n < hi_c + 50) begin
            @(negedge clock);
            n++;
        end
        chk(16'(cyc - t0 >= lo_c && cyc - t0 <= hi_c), 16'h0001);
    endtask
    // Runs the counter from 0xffe0 across a wrap and counts pwm high cycles.
    task automatic pwm_run(input int exp);
        int hi;
        hi = 0;
        wr(`CAWD_ADDR_CONTROL, 8'h00);
        wr(`CAWD_ADDR_CNT_LOW, 8'he0);
        wr(`CAWD_ADDR_CNT_HIGH, 8'hff);
        repeat (5) @(negedge clock);
        rdc(`CAWD_ADDR_CNT_LOW, 8'he0);
        wr(`CAWD_ADDR_CONTROL, 8'h40);
        repeat (60) begin
            @(negedge clock);
            if (pwm_out === 1'b1) hi++;
        end
        chk(16'(hi), 16'(exp));
    endtask
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge clock);
        err_total++;
        print_verdict();
    end
    initial begin
        do_reset();
        rdc(`CAWD_ADDR_MODE, 8'h40);
        rdc(`CAWD_ADDR_CONTROL, 8'h00);
        rdc(`CAWD_ADDR_CH4_LOW, 8'h00);
        rdc(8'h00, 8'h00);
        wr(`CAWD_ADDR_MODE, 8'hc8);
        rdc(`CAWD_ADDR_MODE, 8'h40);
        wr(`CAWD_ADDR_CNT_HIGH, 8'h80);
        rdc(`CAWD_ADDR_CNT_HIGH, 8'h00);
        wait_req(3042, 3086);
        do_reset();
        wr(`CAWD_ADDR_CH4_LOW, 8'h02);
        rd(`CAWD_ADDR_CNT_HIGH, rv);
        rd(`CAWD_ADDR_CNT_LOW, lo0);
        wr(`CAWD_ADDR_CH4_HIGH, 8'h55);
        t0 = cyc;
        rdc(`CAWD_ADDR_CH4_HIGH, rv + 8'h02);
        wr(`CAWD_ADDR_CONTROL, 8'h40);
        rd(`CAWD_ADDR_CONTROL, rv);
        chk(16'(rv[6]), 16'h0001);
        wr(`CAWD_ADDR_CONTROL, 8'h00);
        rd(`CAWD_ADDR_CNT_LOW, lo);
        repeat (30) @(negedge clock);
        rd(`CAWD_ADDR_CNT_LOW, rv);
        chk(16'(rv != lo), 16'h0001);
        w = (768 - int'(lo0)) * 12;
        wait_req(w - 30, w + 14);
        do_reset();
        wr(`CAWD_ADDR_MODE, 8'h60);
        wr(`CAWD_ADDR_MODE, 8'h00);
        rdc(`CAWD_ADDR_MODE, 8'h60);
        rd(`CAWD_ADDR_CH4_MODE, rv);
        wr(`CAWD_ADDR_CH4_MODE, ~rv);
        rdc(`CAWD_ADDR_CH4_MODE, rv);
        // The request stands for one cycle only, so look at the falling edge after the write.
        wr(`CAWD_ADDR_CONTROL, 8'h10);
        chk(16'(wdt_reset_req), 16'h0001);
        do_reset();
        wr(`CAWD_ADDR_MODE, 8'h00);
        wr(`CAWD_ADDR_MODE, 8'h09);
        rdc(`CAWD_ADDR_MODE, 8'h09);
        n_req = req_cnt;
        wr(`CAWD_ADDR_CONTROL, 8'h10);
        wr(`CAWD_ADDR_PWM_LOW, 8'hf0);
        wr(`CAWD_ADDR_PWM_HIGH, 8'hff);
        wr(`CAWD_ADDR_PWM_MODE, 8'hc2);
        pwm_run(16);
        chk(16'(irq), 16'h0001);
        wr(`CAWD_ADDR_CONTROL, 8'h40);
        @(negedge clock);
        chk(16'(irq), 16'h0000);
        wr(`CAWD_ADDR_PWM_LOW, 8'hf0);
        pwm_run(0);
        wr(`CAWD_ADDR_MODE, 8'h89);
        cpu_idle = 1'b1;
        rd(`CAWD_ADDR_CNT_LOW, lo);
        repeat (20) @(negedge clock);
        rdc(`CAWD_ADDR_CNT_LOW, lo);
        cpu_idle = 1'b0;
        repeat (3200) @(negedge clock);
        chk(16'(req_cnt - n_req), 16'h0000);
        print_verdict();
    end
endmodule // cawd_watchdog_tb
